/* pwm_regs.svh */
// Summary of operation
// - Timer counts clock ticks and compares against seven match registers for actions and interrupts.
// - In PWM mode a match on the period match register resets the counter.
// - Single-edge output uses the period register plus one edge match register.
// - Single-edge outputs rise at period match unless held constantly low.
// - Double-edge output uses period register plus rising and falling match registers.
// - Rising match before falling gives positive pulse; reversed order gives negative pulse.
// - Up to six single-edge, three double-edge, or a mix within seven matches.
// - Each match may let the counter run on, optionally raising an interrupt.
// - Each match may stop the timer counter, optionally raising an interrupt.
// - Each match may reset the timer counter, optionally raising an interrupt.
// - In PWM mode new match values apply in step with outputs, only after software releases them; in timer mode at once.
// - Period and width accept any count; all outputs share one repetition rate.
// - Without PWM mode the block is a plain timer with outputs held low.
// - 32-bit timer counter advanced through a 32-bit programmable prescaler.
// - Either double-edge edge may sit at any count position in the cycle.
`ifndef PWM_REGS_SVH
`define PWM_REGS_SVH
`define NUM_MATCH    7
`define OFF_STS      8'h00
`define OFF_TCR      8'h04
`define OFF_TC       8'h08
`define OFF_PR       8'h0C
`define OFF_PC       8'h10
`define OFF_MCR      8'h14
`define OFF_MATCH0   8'h18
`define OFF_MATCH6   8'h30
`define OFF_PCR      8'h34
`define OFF_LER      8'h38
`define OFF_MSK      8'h3C
`define TCR_EN_BIT   0
`define TCR_RST_BIT  1
`define TCR_PWM_BIT  3
`define PCR_OEN_LSB  9
`define RST_WORD     32'h0000_0000
`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2
`endif

/* pwm_pkg.sv */
package pwm_pkg;
    typedef logic [31:0] word_t;
    typedef logic [7:0]  addr_t;
    typedef logic [6:0]  match_vec_t;
    typedef logic [5:0]  out_vec_t;
    // One match register's action bits, interrupt in the low bit
    typedef struct packed {
        logic stop_en;
        logic rst_en;
        logic irq_en;
    } match_ctl_s;
    // Timer control state
    typedef struct packed {
        logic pwm_en;
        logic cnt_rst;
        logic cnt_en;
    } tmr_ctl_s;
endpackage

/* match_pwm.sv */
// Register access over AXI4-Lite and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "pwm_regs.svh"
module match_pwm (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic             s_axi_awvalid,
    output logic                  s_axi_awready,
    input  wire pwm_pkg::addr_t   s_axi_awaddr,
    input  wire logic             s_axi_wvalid,
    output logic                  s_axi_wready,
    input  wire pwm_pkg::word_t   s_axi_wdata,
    input  wire logic [3:0]       s_axi_wstrb,
    output logic                  s_axi_bvalid,
    input  wire logic             s_axi_bready,
    output logic [1:0]            s_axi_bresp,
    input  wire logic             s_axi_arvalid,
    output logic                  s_axi_arready,
    input  wire pwm_pkg::addr_t   s_axi_araddr,
    output logic                  s_axi_rvalid,
    input  wire logic             s_axi_rready,
    output pwm_pkg::word_t        s_axi_rdata,
    output logic [1:0]            s_axi_rresp,
    output pwm_pkg::out_vec_t     pwm_out,
    output logic                  irq
);
    import pwm_pkg::*;

    // Byte strobes widened to a bit mask, shared by every register write
    function automatic word_t lane_mask(input logic [3:0] strb);
        return {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    endfunction

    // Byte-lane merge of a write into an existing word
    function automatic word_t merge(input word_t old, input word_t data, input logic [3:0] strb);
        word_t m;
        m = lane_mask(strb);
        return (old & ~m) | (data & m);
    endfunction

    // Action bits of one match register from the packed control word
    function automatic match_ctl_s mcr_field(input logic [20:0] mcr, input int idx);
        return match_ctl_s'(mcr[3*idx +: 3]);
    endfunction

    // True when the address hits a match holding register
    function automatic logic is_mr(input addr_t a);
        return (a >= `OFF_MATCH0) && (a <= `OFF_MATCH6) && (a[1:0] == 2'h0);
    endfunction

    // Match register index from a byte address
    function automatic logic [2:0] mr_idx(input addr_t a);
        addr_t d;
        d = a - `OFF_MATCH0;
        return d[4:2];
    endfunction

    // Bus slave state
    logic        awready_r;
    logic        wready_r;
    logic        aw_full_r;
    logic        w_full_r;
    addr_t       awaddr_r;
    word_t       wdata_r;
    logic [3:0]  wstrb_r;
    logic        bvalid_r;
    logic [1:0]  bresp_r;
    logic        arready_r;
    logic        rvalid_r;
    word_t       rdata_r;
    logic [1:0]  rresp_r;

    // Block registers
    tmr_ctl_s    tcr_r;
    word_t       tc_r;
    word_t       pr_r;
    word_t       pc_r;
    logic [20:0] mcr_r;
    word_t       mr_hold_r [0:6];
    word_t       mr_act_r  [0:6];
    logic [14:0] pcr_r;
    match_vec_t  ler_r;
    match_vec_t  sts_r;
    match_vec_t  msk_r;
    out_vec_t    lvl_r;
    out_vec_t    pwm_out_r;
    logic        irq_r;

    // Write decode: a write is performed once address and data are both held
    // Unaligned or unmapped addresses hit nothing and answer with a slave error
    wire         wr_fire  = aw_full_r & w_full_r & ~bvalid_r;
    wire         wr_sts   = wr_fire && awaddr_r == `OFF_STS;
    wire         wr_tcr   = wr_fire && awaddr_r == `OFF_TCR;
    wire         wr_tc    = wr_fire && awaddr_r == `OFF_TC;
    wire         wr_pr    = wr_fire && awaddr_r == `OFF_PR;
    wire         wr_pc    = wr_fire && awaddr_r == `OFF_PC;
    wire         wr_mcr   = wr_fire && awaddr_r == `OFF_MCR;
    wire         wr_mr    = wr_fire && is_mr(awaddr_r);
    wire         wr_pcr   = wr_fire && awaddr_r == `OFF_PCR;
    wire         wr_ler   = wr_fire && awaddr_r == `OFF_LER;
    wire         wr_msk   = wr_fire && awaddr_r == `OFF_MSK;
    wire         wr_hit   = wr_sts | wr_tcr | wr_tc | wr_pr | wr_pc | wr_mcr | wr_mr | wr_pcr | wr_ler | wr_msk;
    wire [2:0]   wr_idx   = mr_idx(awaddr_r);
    wire word_t  wr_val   = wdata_r & lane_mask(wstrb_r);
    wire word_t  tcr_word = {28'h0000000, tcr_r.pwm_en, 1'b0, tcr_r.cnt_rst, tcr_r.cnt_en};
    wire word_t  tcr_new  = merge(tcr_word, wdata_r, wstrb_r);
    // Narrow registers read back as zero-extended words; MCR, PCR and MSK also merge in that form
    wire word_t  sts_word = {25'h0, sts_r};
    wire word_t  mcr_word = {11'h0, mcr_r};
    wire word_t  pcr_word = {17'h0, pcr_r};
    wire word_t  ler_word = {25'h0, ler_r};
    wire word_t  msk_word = {25'h0, msk_r};
    wire word_t  mcr_new  = merge(mcr_word, wdata_r, wstrb_r);
    wire word_t  pcr_new  = merge(pcr_word, wdata_r, wstrb_r);
    wire word_t  msk_new  = merge(msk_word, wdata_r, wstrb_r);

    // Read decode
    wire         rd_take  = s_axi_arvalid & arready_r;
    wire         rd_mr    = is_mr(s_axi_araddr);
    wire [2:0]   rd_idx   = mr_idx(s_axi_araddr);
    wire         rd_hit   = rd_mr || s_axi_araddr == `OFF_STS || s_axi_araddr == `OFF_TCR ||
                            s_axi_araddr == `OFF_TC || s_axi_araddr == `OFF_PR || s_axi_araddr == `OFF_PC ||
                            s_axi_araddr == `OFF_MCR || s_axi_araddr == `OFF_PCR ||
                            s_axi_araddr == `OFF_LER || s_axi_araddr == `OFF_MSK;
    // Match addresses read the holding value, not the compare in use
    wire word_t  rd_mux   = rd_mr                        ? mr_hold_r[rd_idx] :
                            s_axi_araddr == `OFF_STS ? sts_word :
                            s_axi_araddr == `OFF_TCR ? tcr_word :
                            s_axi_araddr == `OFF_TC  ? tc_r :
                            s_axi_araddr == `OFF_PR  ? pr_r :
                            s_axi_araddr == `OFF_PC  ? pc_r :
                            s_axi_araddr == `OFF_MCR ? mcr_word :
                            s_axi_araddr == `OFF_PCR ? pcr_word :
                            s_axi_araddr == `OFF_LER ? ler_word :
                            s_axi_araddr == `OFF_MSK ? msk_word : `RST_WORD;

    // Prescaler terminal count advances the timer; a held reset keeps both counters at zero
    // A limit written below the running count is only met after the 32-bit count wraps
    wire         tick     = tcr_r.cnt_en & ~tcr_r.cnt_rst & (pc_r == pr_r);
    match_vec_t  match;
    match_vec_t  m_irq;
    match_vec_t  m_rst;
    match_vec_t  m_stop;

    // Per-match compare and action decode
    generate
        for (genvar i = 0; i < `NUM_MATCH; i++) begin : g_match
            wire match_ctl_s ctl = mcr_field(mcr_r, i);
            assign match[i]  = tick & (tc_r == mr_act_r[i]);
            assign m_irq[i]  = ctl.irq_en;
            assign m_rst[i]  = ctl.rst_en;
            assign m_stop[i] = ctl.stop_en;
        end
    endgenerate

    // Period match always restarts the cycle in PWM mode, so every output shares it
    wire         per_hit  = tcr_r.pwm_en & match[0];
    wire         rst_hit  = |(match & m_rst) | per_hit;
    wire         stop_hit = |(match & m_stop);
    wire match_vec_t ler_clr = per_hit ? ler_r : 7'h00;
    wire match_vec_t ler_set = wr_ler ? wr_val[6:0] : 7'h00;
    // Software release wins over the hardware clear landing in the same cycle
    wire match_vec_t ler_nxt = (ler_r & ~ler_clr) | ler_set;
    wire match_vec_t sts_set = match & m_irq;
    wire match_vec_t sts_clr = wr_sts ? wr_val[6:0] : 7'h00;
    // A match in the clearing cycle keeps its flag
    wire match_vec_t sts_nxt = (sts_r & ~sts_clr) | sts_set;
    wire match_vec_t msk_nxt = wr_msk ? msk_new[6:0] : msk_r;
    wire match_vec_t dbl_sel = {pcr_r[6:2], 2'b00};
    wire out_vec_t   oen     = pcr_r[`PCR_OEN_LSB +: 6];
    out_vec_t        lvl_nxt;

    // Output edge logic: output n clears on match n and sets on match 0 or match n-1
    // Single-edge outputs have no double-edge select, so match 0 opens each cycle
    generate
        for (genvar n = 1; n <= 6; n++) begin : g_out
            wire set_e = dbl_sel[n] ? match[n-1] : match[0];
            wire clr_e = match[n];
            // Clear wins so a match value equal to the period gives a constant low
            assign lvl_nxt[n-1] = ~tcr_r.pwm_en ? 1'b0 :
                                  clr_e ? 1'b0 : set_e ? 1'b1 : lvl_r[n-1];
        end
    endgenerate

    // Write address channel: accepted once, held until the write completes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_r <= 1'b0;
            aw_full_r <= 1'b0;
            awaddr_r  <= 8'h00;
        end else begin
            awready_r <= s_axi_awvalid & ~awready_r & ~aw_full_r & ~bvalid_r;
            if (s_axi_awvalid & awready_r) begin
                aw_full_r <= 1'b1;
                awaddr_r  <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_full_r <= 1'b0;
            end
        end
    end

    // Write data channel, independent of the address channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready_r <= 1'b0;
            w_full_r <= 1'b0;
            wdata_r  <= `RST_WORD;
            wstrb_r  <= 4'h0;
        end else begin
            wready_r <= s_axi_wvalid & ~wready_r & ~w_full_r & ~bvalid_r;
            if (s_axi_wvalid & wready_r) begin
                w_full_r <= 1'b1;
                wdata_r  <= s_axi_wdata;
                wstrb_r  <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_full_r <= 1'b0;
            end
        end
    end

    // Write response; unmapped addresses answer with a slave error
    // bresp stands with bvalid, so a slow master still reads the right code
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r  <= `RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_r <= 1'b1;
            bresp_r  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // Read channel: one cycle from address acceptance to data
    // arready stays low while data waits, so rdata cannot be overwritten
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b0;
            rdata_r   <= `RST_WORD;
            rresp_r   <= `RESP_OKAY;
        end else begin
            arready_r <= s_axi_arvalid & ~arready_r & ~rvalid_r;
            if (rd_take) begin
                rvalid_r <= 1'b1;
                rdata_r  <= rd_mux;
                rresp_r  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_rready) begin
                rvalid_r <= 1'b0;
            end
        end
    end

    // Timer control: a stop action clears the enable unless software writes this cycle
    // Stop clears only the enable; count and flags stay for software to read
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tcr_r <= '0;
        end else if (wr_tcr) begin
            tcr_r <= {tcr_new[`TCR_PWM_BIT], tcr_new[`TCR_RST_BIT], tcr_new[`TCR_EN_BIT]};
        end else if (stop_hit) begin
            tcr_r.cnt_en <= 1'b0;
        end
    end

    // Prescaler counts clocks up to its limit, then wraps and ticks the timer
    // A new limit does not restart the count in progress
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pr_r <= `RST_WORD;
            pc_r <= `RST_WORD;
        end else begin
            if (wr_pr) begin
                pr_r <= merge(pr_r, wdata_r, wstrb_r);
            end
            if (tcr_r.cnt_rst) begin
                pc_r <= `RST_WORD;
            end else if (wr_pc) begin
                pc_r <= merge(pc_r, wdata_r, wstrb_r);
            end else if (tcr_r.cnt_en) begin
                pc_r <= tick ? `RST_WORD : pc_r + 32'h0000_0001;
            end
        end
    end

    // Timer counter: reset action restarts the count, wrapping is natural at 32 bits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tc_r <= `RST_WORD;
        end else if (tcr_r.cnt_rst) begin
            tc_r <= `RST_WORD;
        end else if (wr_tc) begin
            tc_r <= merge(tc_r, wdata_r, wstrb_r);
        end else if (tick) begin
            tc_r <= rst_hit ? `RST_WORD : tc_r + 32'h0000_0001;
        end
    end

    // Match control and output configuration
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mcr_r <= 21'h000000;
            pcr_r <= 15'h0000;
        end else begin
            if (wr_mcr) begin
                mcr_r <= mcr_new[20:0];
            end
            if (wr_pcr) begin
                pcr_r <= pcr_new[14:0];
            end
        end
    end

    // Holding and active match registers; outside PWM mode the holding value applies directly
    generate
        for (genvar i = 0; i < `NUM_MATCH; i++) begin : g_mr
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    mr_hold_r[i] <= `RST_WORD;
                    mr_act_r[i]  <= `RST_WORD;
                end else begin
                    if (wr_mr && wr_idx == 3'(i)) begin
                        mr_hold_r[i] <= merge(mr_hold_r[i], wdata_r, wstrb_r);
                    end
                    // Swapping only at the period match avoids a half-updated cycle
                    if (!tcr_r.pwm_en || ler_clr[i]) begin
                        mr_act_r[i] <= mr_hold_r[i];
                    end
                end
            end
        end
    endgenerate

    // Release bits, interrupt flags, mask and interrupt line
    // The line follows next-state flags so it rises together with the flag
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ler_r <= 7'h00;
            sts_r <= 7'h00;
            msk_r <= 7'h00;
            irq_r <= 1'b0;
        end else begin
            ler_r <= ler_nxt;
            sts_r <= sts_nxt;
            msk_r <= msk_nxt;
            irq_r <= |(sts_nxt & msk_nxt);
        end
    end

    // Pin levels: only enabled outputs in PWM mode leave the low state
    // Pins come from a flop of their own, loaded at the same clock as the internal level
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lvl_r     <= 6'h00;
            pwm_out_r <= 6'h00;
        end else begin
            lvl_r     <= lvl_nxt;
            pwm_out_r <= lvl_nxt & oen;
        end
    end

    // Every output port is a register
    assign s_axi_awready = awready_r;
    assign s_axi_wready  = wready_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;
    assign pwm_out       = pwm_out_r;
    assign irq           = irq_r;

endmodule // match_pwm

/* pwm_load_model.sv */
`timescale 1ns/1ps
// Load on the outputs: measures each pin's high time and rise-to-rise period in clocks
module pwm_load_model (
    input  wire logic              aclk,
    input  wire pwm_pkg::out_vec_t pwm_out,
    output logic [15:0]            high_len [6],
    output logic [15:0]            period_len [6]
);
    import pwm_pkg::*;
    out_vec_t    prev_r;
    logic [15:0] hi_r  [6];
    logic [15:0] run_r [6];
    // A load sees only the pin level, so every figure is taken from its own rising edge
    always_ff @(posedge aclk) begin
        prev_r <= pwm_out;
        for (int k = 0; k < 6; k++) begin
            run_r[k] <= (pwm_out[k] && !prev_r[k]) ? 16'h1 : run_r[k] + 16'h1;
            hi_r[k]  <= (pwm_out[k] && !prev_r[k]) ? 16'h1 : hi_r[k] + 16'h1;
            if (pwm_out[k] && !prev_r[k])
                period_len[k] <= run_r[k];
            if (!pwm_out[k] && prev_r[k])
                high_len[k] <= hi_r[k];
        end
    end
endmodule // pwm_load_model

/* match_pwm_properties.sv */
`timescale 1ns/1ps
module match_pwm_properties (
    input wire logic           aclk,
    input wire logic           aresetn,
    input wire logic           s_axi_awvalid,
    input wire logic           s_axi_awready,
    input wire logic           s_axi_wvalid,
    input wire logic           s_axi_wready,
    input wire logic           s_axi_bvalid,
    input wire logic           s_axi_bready,
    input wire logic [1:0]     s_axi_bresp,
    input wire logic           s_axi_arvalid,
    input wire logic           s_axi_arready,
    input wire pwm_pkg::addr_t s_axi_araddr,
    input wire logic           s_axi_rvalid,
    input wire logic           s_axi_rready,
    input wire pwm_pkg::word_t s_axi_rdata,
    input wire logic [1:0]     s_axi_rresp,
    input wire logic           irq
);
    import pwm_pkg::*;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Ready strobes are single pulses, so a held valid is never taken twice
    AST_AW_PULSE: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("awready held longer than one cycle");
    AST_AR_PULSE: assert property (s_axi_arready |=> !s_axi_arready)
        else $error("arready held longer than one cycle");
    AST_B_AFTER_BOTH: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid)
        else $error("write response not two cycles after address and data");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before bready");
    AST_R_AFTER_AR: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data not one cycle after address taken");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read data changed before rready");
    AST_RVALID_CAUSE: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arready))
        else $error("read data without a taken address");
    AST_UNMAPPED_RD: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h3C
        |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
        else $error("unmapped read not answered with error and zero");
    // Flags only clear by software; the write that drops irq raises bvalid at the same edge
    AST_IRQ_FALL: assert property ($fell(irq) |-> s_axi_bvalid)
        else $error("interrupt fell without a register write");
    COV_WRITE: cover property (s_axi_bvalid && s_axi_bready);
    COV_READ: cover property (s_axi_rvalid && s_axi_rready);
    COV_IRQ: cover property ($rose(irq));
endmodule // match_pwm_properties

bind match_pwm match_pwm_properties u_props (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .irq(irq)
);

/* match_based_pwm_unit_test.sv */
`timescale 1ns/1ps
`include "pwm_regs.svh"
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin err_count++; \
    $display("ERROR at %0t: got %0h expected %0h", $time, got, exp); end end
module match_based_pwm_unit_test;
    import pwm_pkg::*;
    typedef struct packed {
        addr_t      addr;
        word_t      wdata;
        logic [3:0] strb;
        word_t      rexp;
        logic [1:0] bexp;
        logic [1:0] rrexp;
    } row_s;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp, rs;
    logic [3:0] wstrb = 4'h0;
    addr_t awaddr = 8'h00, araddr = 8'h00;
    word_t wdata = 32'h0, rdata, rd;
    out_vec_t pwm_out;
    logic [15:0] high_len [6];
    logic [15:0] period_len [6];
    int err_count = 0, n_checks = 0, cyc = 0;
    // Register table rows, last one unmapped
    row_s rows [8] = '{
        '{`OFF_PR, 32'h1122_3344, 4'hF, 32'h1122_3344, `RESP_OKAY, `RESP_OKAY},
        '{`OFF_PR, 32'hAABB_CCDD, 4'h3, 32'h1122_CCDD, `RESP_OKAY, `RESP_OKAY},
        '{`OFF_MATCH0, 32'hFFFF_FFFF, 4'hF, 32'hFFFF_FFFF, `RESP_OKAY, `RESP_OKAY},
        '{`OFF_MATCH6, 32'h1234_5678, 4'hF, 32'h1234_5678, `RESP_OKAY, `RESP_OKAY},
        '{`OFF_MCR, 32'h0001_2345, 4'hF, 32'h0001_2345, `RESP_OKAY, `RESP_OKAY},
        '{`OFF_PCR, 32'h0000_7E7C, 4'hF, 32'h0000_7E7C, `RESP_OKAY, `RESP_OKAY},
        '{`OFF_MSK, 32'h0000_007F, 4'hF, 32'h0000_007F, `RESP_OKAY, `RESP_OKAY},
        '{8'h40, 32'h0000_005A, 4'hF, 32'h0000_0000, `RESP_SLVERR, `RESP_SLVERR}};

    match_pwm u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .pwm_out(pwm_out), .irq(irq));
    pwm_load_model u_load (.aclk(aclk), .pwm_out(pwm_out), .high_len(high_len), .period_len(period_len));

    always #2 aclk = ~aclk;
    // Hang guard, far above the few hundred cycles the sequence needs
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 6000) begin
            err_count++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        if (err_count == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Address and data offered together; bready raised only once the answer is seen
    task automatic axi_wr(input addr_t a, input word_t d, input logic [3:0] s, output logic [1:0] r);
        bit ad = 0;
        bit wd = 0;
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge aclk);
            if (!ad && awready === 1'b1) begin
                ad = 1;
                awvalid <= 1'b0;
            end
            if (!wd && wready === 1'b1) begin
                wd = 1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        bready <= 1'b1;
        @(posedge aclk);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic axi_rd(input addr_t a, output word_t d, output logic [1:0] r);
        araddr  <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rready <= 1'b1;
        @(posedge aclk);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task automatic put(input addr_t a, input word_t d);
        axi_wr(a, d, 4'hF, rs);
        `CHK(rs, `RESP_OKAY)
    endtask
    task automatic get(input addr_t a, input word_t e);
        axi_rd(a, rd, rs);
        `CHK(rd, e)
    endtask
    // Output k+1 figures in clocks: prescaler of two, cycle of ten ticks
    function automatic logic [15:0] ticks(input int n);
        return 16'(n * 2);
    endfunction
    task automatic check_out(input int h1, input int h2);
        `CHK(period_len[0], ticks(10))
        `CHK(period_len[1], ticks(10))
        `CHK(high_len[0], ticks(h1))
        `CHK(high_len[1], ticks(h2))
    endtask

    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int a = 0; a < 64; a += 4)
            get(addr_t'(a), `RST_WORD);
        `CHK(pwm_out, 6'h00)
        foreach (rows[i]) begin
            axi_wr(rows[i].addr, rows[i].wdata, rows[i].strb, rs);
            `CHK(rs, rows[i].bexp)
            axi_rd(rows[i].addr, rd, rs);
            `CHK(rd, rows[i].rexp)
            `CHK(rs, rows[i].rrexp)
        end
        // Active compares follow holding values while still in timer mode
        put(`OFF_PR, 32'h1);
        put(`OFF_MATCH0, 32'h9);
        put(`OFF_MATCH0 + 8'h4, 32'h2);
        put(`OFF_MATCH0 + 8'h8, 32'h7);
        put(`OFF_PCR, 32'h604);
        put(`OFF_MCR, 32'h1);
        put(`OFF_MSK, 32'h1);
        put(`OFF_TCR, 32'h9);
        repeat (80) @(posedge aclk);
        check_out(3, 5);
        `CHK(irq, 1'b1)
        put(`OFF_MSK, 32'h0);
        repeat (3) @(posedge aclk);
        `CHK(irq, 1'b0)
        // New values held back until released
        put(`OFF_MATCH0 + 8'h4, 32'h8);
        put(`OFF_MATCH0 + 8'h8, 32'h1);
        repeat (80) @(posedge aclk);
        check_out(3, 5);
        put(`OFF_LER, 32'h6);
        repeat (80) @(posedge aclk);
        check_out(9, 3);
        put(`OFF_MCR, 32'h5);
        repeat (40) @(posedge aclk);
        get(`OFF_TCR, 32'h8);
        get(`OFF_TC, 32'h0);
        put(`OFF_MSK, 32'h1);
        repeat (3) @(posedge aclk);
        `CHK(irq, 1'b1)
        get(`OFF_STS, 32'h1);
        put(`OFF_STS, 32'h1);
        repeat (3) @(posedge aclk);
        `CHK(irq, 1'b0)
        get(`OFF_STS, 32'h0);
        // Plain timer: reset on match three, interrupt flag on match one
        put(`OFF_TCR, 32'h2);
        put(`OFF_PR, 32'h0);
        put(`OFF_MATCH0 + 8'h4, 32'h2);
        put(`OFF_MATCH0 + 8'hC, 32'h5);
        put(`OFF_MCR, 32'h408);
        put(`OFF_TCR, 32'h1);
        repeat (30) @(posedge aclk);
        `CHK(pwm_out, 6'h00)
        for (int i = 0; i < 4; i++) begin
            axi_rd(`OFF_TC, rd, rs);
            `CHK(rd < 32'h6, 1'b1)
        end
        get(`OFF_STS, 32'h2);
        print_verdict();
    end
endmodule // match_based_pwm_unit_test
